// >>> logic/sleep_mode_controller.sv
/*
  sleep mode controller: apb control register, sleep entry on the core's
  sleep instruction, wake qualification, wake latency and gating outputs.
  assumes pclk is the peripheral clock, presetn is asserted by every system
  reset source, and inputs are synchronous to pclk.
*/
// Summary of operation
// - idle halts the core; all peripherals and clocks keep running.
// - in idle every enabled interrupt wakes the device.
// - in standby a peripheral runs only if its run_in_standby is set.
// - in standby the converter may run on without waking the core.
// - standby wakes on pin, twi match, periodic and capture timers, and gated serial, converter, rtc; never other.
// - power down keeps only watchdog and brown-out detector alive.
// - power down wakes only on pin change or twi address match.
// - code resumes 6 clock cycles after the main clock is ready.
// - idle keeps the main source running, no oscillator delay.
// - power down stops all sources but the slow one if needed.
// - with brown-out mode 0x3 wake waits for detector ready too.
// - state select bits 2:1: 0 idle, 1 standby, 2 power down.
// - after wake the handler runs, then the next instruction.
// - any reset forces the device out of sleep.
// - a debug break while asleep returns to active mode.
module sleep_mode_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire logic [sleep_pkg::wake_n-1:0] irq,
  input wire logic [sleep_pkg::periph_n-1:0] run_in_standby,
  input wire logic debug_break,
  input wire logic main_clk_ready,
  input wire logic [1:0] bod_active_mode,
  input wire logic bod_ready,
  input wire logic wdt_or_bod_need_slow,
  output logic sleep_taken,
  output logic core_run,
  output logic core_resume,
  output logic [sleep_pkg::periph_n-1:0] periph_run,
  output logic main_osc_run,
  output logic slow_osc_run,
  output logic asleep
);
  // ==========================================================
  // state
  sleep_pkg::ctl_state_t state_q;
  sleep_pkg::ctl_state_t state_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [1:0] mode_q;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic taken_q;
  logic resume_q;
  logic core_run_q;
  logic [sleep_pkg::periph_n-1:0] periph_q;
  logic main_q;
  logic slow_q;
  logic asleep_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ==========================================================
  // apb decode
  logic setup;
  logic hit;
  logic do_write;
  logic do_read;
  logic [7:0] wr_val;
  assign setup = psel && !penable;
  assign hit = (paddr[7:2] == sleep_pkg::sleep_control_addr[7:2]) && (paddr[1:0] == 2'h0);
  // answer one cycle after setup; access completes on the first access edge
  assign do_write = psel && penable && pready_q && pwrite && hit;
  assign do_read = setup && !pwrite && hit;
  assign wr_val = (ctrl_q & ~sleep_pkg::sleep_control_wmask)
                | (pwdata[7:0] & sleep_pkg::sleep_control_wmask);
  // reserved bits 7:3 stay zero; encoding kept as written
  assign ctrl_d = (do_write && pstrb[0]) ? wr_val : ctrl_q;

  // ==========================================================
  // sleep sequencing
  logic allow;
  logic [1:0] sel;
  logic enter;
  logic wake_req;
  logic bod_hold;
  logic count_done;
  assign allow = ctrl_q[sleep_pkg::sleep_allow_bit];
  assign sel = ctrl_q[sleep_pkg::state_sel_hi:sleep_pkg::state_sel_lo];
  // reserved selection is refused rather than guessed
  assign enter = (state_q == sleep_pkg::st_active) && sleep_instr && allow
               && (sel != 2'h3);
  assign bod_hold = (bod_active_mode == sleep_pkg::bod_wait_mode) && !bod_ready;
  assign count_done = (cnt_q == 3'h0);

  sleep_wake_filter u_filter (
    .state_sel(mode_q),
    .run_in_standby(run_in_standby),
    .irq(irq),
    .wake(wake_req)
  );

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      sleep_pkg::st_active: begin
        if (enter) begin
          state_d = sleep_pkg::st_sleep;
        end
      end
      sleep_pkg::st_sleep: begin
        if (wake_req || debug_break) begin
          state_d = sleep_pkg::st_wake;
          cnt_d = sleep_pkg::wake_count_init;
        end
      end
      sleep_pkg::st_wake: begin
        // latency counts only once the main source is up
        if (main_clk_ready && !count_done) begin
          cnt_d = cnt_q - 3'h1;
        end
        // early detector ready leaves the net delay unchanged
        if (count_done && !bod_hold) begin
          state_d = sleep_pkg::st_resume;
        end
      end
      sleep_pkg::st_resume: begin
        state_d = sleep_pkg::st_active;
      end
      default: begin
        state_d = sleep_pkg::st_active;
      end
    endcase
  end

  // ==========================================================
  // gating
  logic asleep_w;
  logic core_run_w;
  logic [sleep_pkg::periph_n-1:0] periph_w;
  logic main_w;
  logic slow_w;
  logic asleep_d;
  assign asleep_d = (state_d == sleep_pkg::st_sleep) || (state_d == sleep_pkg::st_wake);
  // wake phase keeps the sleeping view until code resumes
  assign asleep_w = asleep_d;
  // main source is requested while waking, else its ready never arrives
  logic waking;
  assign waking = (state_d == sleep_pkg::st_wake);

  sleep_gate_map u_gate (
    .asleep(asleep_w),
    .state_sel(enter ? sel : mode_q),
    .run_in_standby(run_in_standby),
    .wdt_or_bod_need_slow(wdt_or_bod_need_slow),
    .core_run(core_run_w),
    .periph_run(periph_w),
    .main_osc_run(main_w),
    .slow_osc_run(slow_w)
  );

  // ==========================================================
  // registers, reset forces active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= sleep_pkg::st_active;
      ctrl_q <= sleep_pkg::sleep_control_rst;
      mode_q <= sleep_pkg::sel_idle;
      cnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      cnt_q <= cnt_d;
      if (enter) begin
        mode_q <= sel;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_q <= 1'b0;
      resume_q <= 1'b0;
      core_run_q <= 1'b1;
      periph_q <= {sleep_pkg::periph_n{1'b1}};
      main_q <= 1'b1;
      slow_q <= 1'b1;
      asleep_q <= 1'b0;
    end else begin
      taken_q <= enter;
      resume_q <= (state_d == sleep_pkg::st_resume);
      core_run_q <= core_run_w;
      periph_q <= periph_w;
      main_q <= main_w || waking;
      slow_q <= slow_w;
      asleep_q <= asleep_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !hit;
      prdata_q <= do_read ? {24'h00_0000, ctrl_q} : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sleep_taken = taken_q;
  assign core_resume = resume_q;
  assign core_run = core_run_q;
  assign periph_run = periph_q;
  assign main_osc_run = main_q;
  assign slow_osc_run = slow_q;
  assign asleep = asleep_q;
endmodule : sleep_mode_controller

// >>> logic/sleep_pkg.sv
/*
  constants, encodings and types shared by the sleep mode controller files.
  assumes a 100 MHz peripheral clock and a 32-bit apb register bus.
*/
package sleep_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] sleep_control_addr = 8'h00;
  localparam logic [7:0] sleep_control_rst = 8'h00;
  localparam int sleep_allow_bit = 0;
  localparam int state_sel_lo = 1;
  localparam int state_sel_hi = 2;
  localparam logic [7:0] sleep_control_wmask = 8'h07;
  // ==========================================================
  // sleep state select encodings
  localparam logic [1:0] sel_idle = 2'h0;
  localparam logic [1:0] sel_standby = 2'h1;
  localparam logic [1:0] sel_power_down = 2'h2;
  // ==========================================================
  // brown-out active-mode value that stretches wake-up
  localparam logic [1:0] bod_wait_mode = 2'h3;
  // ==========================================================
  // timing
  localparam int wake_cycles = 6;
  localparam logic [2:0] wake_count_init = 3'h6;
  // ==========================================================
  // peripheral enable vector layout
  localparam int periph_n = 4;
  localparam int p_serial = 0;
  localparam int p_converter = 1;
  localparam int p_rtc = 2;
  localparam int p_other = 3;
  // wake source vector layout
  localparam int wake_n = 8;
  localparam int w_pin = 0;
  localparam int w_twi = 1;
  localparam int w_periodic = 2;
  localparam int w_capture = 3;
  localparam int w_serial_sof = 4;
  localparam int w_conv_window = 5;
  localparam int w_rtc = 6;
  localparam int w_other = 7;
  // ==========================================================
  // controller states, gray along active-sleep-wake-resume-active
  typedef enum logic [1:0] {
    st_active = 2'b00,
    st_sleep = 2'b01,
    st_wake = 2'b11,
    st_resume = 2'b10
  } ctl_state_t;
endpackage : sleep_pkg

// >>> logic/sleep_wake_filter.sv
/*
  wake source qualification: which interrupts may wake the device for a
  given sleep state. assumes interrupt inputs are already enable-gated.
*/
module sleep_wake_filter (
  input wire logic [1:0] state_sel,
  input wire logic [sleep_pkg::periph_n-1:0] run_in_standby,
  input wire logic [sleep_pkg::wake_n-1:0] irq,
  output logic wake
);
  // ==========================================================
  // per source permission
  logic [sleep_pkg::wake_n-1:0] allow_standby;
  logic [sleep_pkg::wake_n-1:0] allow_power_down_state;
  logic [sleep_pkg::wake_n-1:0] allow;

  assign allow_standby[sleep_pkg::w_pin] = 1'b1;
  assign allow_standby[sleep_pkg::w_twi] = 1'b1;
  assign allow_standby[sleep_pkg::w_periodic] = 1'b1;
  assign allow_standby[sleep_pkg::w_capture] = 1'b1;
  assign allow_standby[sleep_pkg::w_serial_sof] = run_in_standby[sleep_pkg::p_serial];
  assign allow_standby[sleep_pkg::w_conv_window] = run_in_standby[sleep_pkg::p_converter];
  assign allow_standby[sleep_pkg::w_rtc] = run_in_standby[sleep_pkg::p_rtc];
  assign allow_standby[sleep_pkg::w_other] = 1'b0;

  genvar i;
  generate
    for (i = 0; i < sleep_pkg::wake_n; i++) begin : g_pd
      // only pin change and address match survive power down
      assign allow_power_down_state[i] = (i == sleep_pkg::w_pin) || (i == sleep_pkg::w_twi);
    end
  endgenerate

  assign allow = (state_sel == sleep_pkg::sel_idle) ? {sleep_pkg::wake_n{1'b1}} :
                 (state_sel == sleep_pkg::sel_standby) ? allow_standby :
                 (state_sel == sleep_pkg::sel_power_down) ? allow_power_down_state :
                 {sleep_pkg::wake_n{1'b0}};
  assign wake = |(irq & allow);
endmodule : sleep_wake_filter

// >>> logic/sleep_gate_map.sv
/*
  clock and peripheral gating per sleep state.
  assumes the clock controller honours the request outputs.
*/
module sleep_gate_map (
  input wire logic asleep,
  input wire logic [1:0] state_sel,
  input wire logic [sleep_pkg::periph_n-1:0] run_in_standby,
  input wire logic wdt_or_bod_need_slow,
  output logic core_run,
  output logic [sleep_pkg::periph_n-1:0] periph_run,
  output logic main_osc_run,
  output logic slow_osc_run
);
  // ==========================================================
  // decode
  logic in_idle;
  logic in_standby;
  logic in_power_down_state;
  assign in_idle = asleep && (state_sel == sleep_pkg::sel_idle);
  assign in_standby = asleep && (state_sel == sleep_pkg::sel_standby);
  assign in_power_down_state = asleep && (state_sel == sleep_pkg::sel_power_down);

  assign core_run = !asleep;

  genvar i;
  generate
    for (i = 0; i < sleep_pkg::periph_n; i++) begin : g_per
      // idle keeps all, standby per setting, power down none
      assign periph_run[i] = !asleep || in_idle || (in_standby && run_in_standby[i]);
    end
  endgenerate

  // main source stays up in idle so wake adds no start-up
  assign main_osc_run = !asleep || in_idle || (in_standby && |run_in_standby);
  // watchdog or brown-out detector need keeps the slow source alive
  assign slow_osc_run = !in_power_down_state || wdt_or_bod_need_slow;
endmodule : sleep_gate_map

// >>> sim/sleep_mode_properties.sv
/*
  checker for the sleep mode controller: apb answers, entry, gating, wake.
  assumes standby and slow-clock inputs stay steady while asleep.
*/
module sleep_mode_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_instr,
  input wire logic [1:0] bod_active_mode,
  input wire logic bod_ready,
  input wire logic sleep_taken,
  input wire logic core_run,
  input wire logic core_resume,
  input wire logic [sleep_pkg::periph_n-1:0] periph_run,
  input wire logic main_osc_run,
  input wire logic asleep
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // shadow of the control register and the latched mode
  logic [2:0] r_q;
  logic [1:0] m_q;
  wire wr = psel && penable && pwrite && paddr == 8'h00 && pstrb[0];
  wire act = core_run && !asleep;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= 3'h0;
      m_q <= 2'h0;
    end else begin
      if (wr) r_q <= pwdata[2:0];
      if (sleep_instr && act) m_q <= r_q[2:1];
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_enter; sleep_taken && asleep && !core_run; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_slverr; s_setup ##0 paddr != 8'h00 |=> pslverr; endproperty
  property p_rdata; s_setup ##0 (!pwrite && paddr == 8'h00) |=> prdata == {29'h0, r_q};
  endproperty
  property p_enter; sleep_instr && act && r_q[0] && r_q[2:1] != 2'h3 |=> s_enter; endproperty
  property p_refuse; sleep_instr && act && !r_q[0] |=> !sleep_taken && core_run; endproperty
  property p_idle; s_enter ##0 m_q == 2'h0 |-> periph_run == 4'hF && main_osc_run; endproperty
  property p_power_down_state; s_enter ##0 m_q == 2'h2 |-> periph_run == 4'h0 && !main_osc_run;
  endproperty
  property p_bod; asleep && bod_active_mode == 2'h3 && !bod_ready |=> !core_resume; endproperty
  property p_resume; core_resume |-> $past(asleep, 6) ##1 (core_run && !asleep); endproperty
  a_ready: assert property (p_ready) else $error("pready missing after setup");
  a_slverr: assert property (p_slverr) else $error("no error on unmapped address");
  a_rdata: assert property (p_rdata) else $error("read data differs from register");
  a_enter: assert property (p_enter) else $error("sleep entry not taken");
  a_refuse: assert property (p_refuse) else $error("sleep taken while not allowed");
  a_idle: assert property (p_idle) else $error("idle gating wrong");
  a_power_down_state: assert property (p_power_down_state) else $error("power down gating wrong");
  a_bod: assert property (p_bod) else $error("resume before detector ready");
  a_resume: assert property (p_resume) else $error("resume sequence wrong");
endmodule : sleep_mode_properties

bind sleep_mode_controller sleep_mode_properties u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_instr,
  .bod_active_mode, .bod_ready, .sleep_taken, .core_run, .core_resume, .periph_run,
  .main_osc_run, .asleep);

// >>> sim/core_model.sv
/*
  core model: issues the sleep instruction and counts resumes.
  assumes the bench raises go for one cycle per sleep attempt.
*/
module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic core_resume,
  output logic sleep_instr,
  output int resumes
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // one-cycle pulse, changed just after the edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr <= 1'b0;
      resumes <= 0;
    end else begin
      sleep_instr <= go;
      if (core_resume) resumes <= resumes + 1;
    end
  end
endmodule : core_model

// >>> sim/test_sleep_mode_controller.sv
/*
  bench for the sleep mode controller: register, entry, wake, gating.
  assumes the checker and core model are compiled before it.
*/
module test_sleep_mode_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] irq = 0;
  logic [3:0] run_in_standby = 0;
  logic debug_break = 0;
  logic main_clk_ready = 1;
  logic [1:0] bod_active_mode = 0;
  logic bod_ready = 1;
  logic wdt_or_bod_need_slow = 0;
  logic go = 0;
  logic [31:0] prdata;
  logic [3:0] periph_run;
  logic pready, pslverr, sleep_instr, sleep_taken, core_run, core_resume;
  logic main_osc_run, slow_osc_run, asleep;
  int resumes, num_errors = 0, checks = 0, nres = 0;
  sleep_mode_controller u_sleep_mode_controller (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_instr, .irq,
    .run_in_standby, .debug_break, .main_clk_ready, .bod_active_mode, .bod_ready,
    .wdt_or_bod_need_slow, .sleep_taken, .core_run, .core_resume, .periph_run,
    .main_osc_run, .slow_osc_run, .asleep);
  core_model u_core_model (.pclk, .presetn, .go, .core_resume, .sleep_instr, .resumes);
  always #5 pclk = ~pclk;
  // ==========================================================
  // tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // waits for pready; only the watchdog ends a stuck wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic enter(input logic [2:0] c);
    logic [31:0] r;
    logic e;
    apb(1, 8'h00, {29'h0, c}, r, e);
    go <= 1;
    @(posedge pclk);
    go <= 0;
    repeat (3) @(posedge pclk);
  endtask : enter
  task automatic ignore(input logic [7:0] q);
    irq <= q;
    repeat (20) @(posedge pclk);
    chk("asleep held", 1, asleep);
    irq <= 0;
    @(posedge pclk);
  endtask : ignore
  // d: main clock start delay, b: detector ready delay
  task automatic wake(input logic [7:0] q, input logic g, input int d, input int b,
                      output int n);
    n = 0;
    irq <= q;
    debug_break <= g;
    while (core_resume !== 1'b1 && n < 300) begin
      main_clk_ready <= (n >= d);
      bod_ready <= (n >= b);
      @(posedge pclk);
      n++;
    end
    irq <= 0;
    debug_break <= 0;
    main_clk_ready <= 1;
    bod_ready <= 1;
    repeat (2) @(posedge pclk);
    chk("wake in time", 1, n < 300);
    nres++;
    chk("run after wake", 1, core_run);
    chk("resumes", nres, resumes);
    $display("wake test done, latency %0d", n);
  endtask : wake
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r, v;
    logic e;
    int lat, d;
    void'($urandom(32'h3b27));
    wdt_or_bod_need_slow <= $urandom % 2;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h00, 0, r, e);
    chk("reset value", 32'h0, r);
    repeat (4) begin
      v = $urandom;
      apb(1, 8'h00, v, r, e);
      apb(0, 8'h00, 0, r, e);
      chk("readback", {29'h0, v[2:0]}, r);
    end
    apb(1, 8'h04, ~v, r, e);
    chk("unmapped", 1, e);
    pstrb <= 4'h0;
    apb(1, 8'h00, ~v, r, e);
    pstrb <= 4'hF;
    apb(0, 8'h00, 0, r, e);
    chk("ignored writes", {29'h0, v[2:0]}, r);
    $display("register test done");
    enter(3'h0);
    chk("refused sleep", 0, asleep);
    enter(3'h7);
    chk("reserved sleep", 0, asleep);
    enter(3'h1);
    chk("idle gating", 5'h1F, {periph_run, main_osc_run});
    wake(8'h80, 0, 0, 0, lat);
    chk("idle latency", 1, lat >= 7 && lat <= 12);
    enter(3'h3);
    chk("standby gating", 0, periph_run);
    ignore(8'hF0);
    wake(8'h08, 0, 0, 0, lat);
    run_in_standby <= 4'h2;
    enter(3'h3);
    chk("standby conv", 4'h2, periph_run);
    ignore(8'hD0);
    wake(8'h20, 0, 0, 0, lat);
    run_in_standby <= 4'h0;
    enter(3'h5);
    chk("power_down_state gating", {5'h0, wdt_or_bod_need_slow},
        {periph_run, main_osc_run, slow_osc_run});
    ignore(8'hFC);
    d = 5 + $urandom % 16;
    wake(8'h01, 0, d, 0, lat);
    chk("slow clock latency", 1, lat >= d + 6);
    bod_active_mode <= 2'h3;
    enter(3'h5);
    wake(8'h02, 0, 0, 30, lat);
    chk("detector latency", 1, lat > 30);
    bod_active_mode <= 2'h0;
    enter(3'h3);
    wake(8'h00, 1, 0, 0, lat);
    enter(3'h5);
    presetn <= 0;
    @(posedge pclk);
    chk("reset wakes", 2'h2, {core_run, asleep});
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h00, 0, r, e);
    chk("reset clears", 32'h0, r);
    $display("reset test done");
    end_of_test;
  end
  // whole run is a few hundred cycles
  initial begin
    #100us;
    num_errors++;
    end_of_test;
  end
endmodule : test_sleep_mode_controller
